// File: logic/rsml_cfg.svh
// Constants of the remote slave map and link health register group.
// Assumes inclusion by bare name from every file that needs offsets or fields.
`ifndef RSML_CFG_SVH
`define RSML_CFG_SVH

`define RSML_OFS_CONTROL 8'h04
`define RSML_OFS_TARGET 8'h07
`define RSML_OFS_ALIAS 8'h08
`define RSML_OFS_COUNT_LOW 8'h0a
`define RSML_OFS_COUNT_HIGH 8'h0b
`define RSML_OFS_STATUS 8'h0c
`define RSML_OFS_PORT_SELECT 8'h10
`define RSML_OFS_IRQ_STATUS 8'h11
`define RSML_OFS_IRQ_MASK 8'h12

`define RSML_BIT_CRC_RESET 5
`define RSML_BIT_PORT_SELECT 0
`define RSML_BIT_LINK_LOST 4
`define RSML_BIT_SELF_TEST_ERR 3
`define RSML_BIT_CLOCK_PRESENT 2
`define RSML_BIT_REMOTE_ERR 1
`define RSML_BIT_LINK_DETECT 0

`define RSML_IRQ_LINK_LOST 0
`define RSML_IRQ_REMOTE_ERR 1
`define RSML_IRQ_SELF_TEST_ERR 2
`define RSML_IRQ_CLOCK_CHANGE 3
`define RSML_IRQ_COUNT_WRAP 4

`define RSML_RESET_ADDR 7'h00
`define RSML_RESET_COUNT 16'h0000
`define RSML_RESET_BYTE 8'h00

`endif

// File: logic/rsml_pkg.sv
// Types shared by the remote slave map and link health register group.
// Assumes nothing beyond a SystemVerilog compiler.
package rsml_pkg;
  typedef logic [7:0] rsml_byte_t;
  typedef logic [6:0] rsml_i2c_addr_t;
  typedef logic [15:0] rsml_count_t;
  typedef logic [0:0] rsml_port_t;
endpackage : rsml_pkg

// File: logic/rsml_port_if.sv
// Bundle between the register front end and one per-port state block.
// Assumes both ends run on the same clock.
interface rsml_port_if;
  import rsml_pkg::*;
  logic wrTarget;
  logic wrAlias;
  rsml_byte_t wrData;
  logic crcClear;
  logic crcErr;
  logic bistActive;
  logic bistRestart;
  logic linkUp;
  logic linkDownEvt;
  rsml_i2c_addr_t target;
  rsml_i2c_addr_t aliasAddr;
  rsml_count_t count;
  logic linkLost;
  logic bistErr;
  logic desErr;
  logic countWrap;
  modport ctl (
    output wrTarget, wrAlias, wrData, crcClear, crcErr, bistActive, bistRestart,
    output linkUp, linkDownEvt,
    input target, aliasAddr, count, linkLost, bistErr, desErr, countWrap
  );
  modport st (
    input wrTarget, wrAlias, wrData, crcClear, crcErr, bistActive, bistRestart,
    input linkUp, linkDownEvt,
    output target, aliasAddr, count, linkLost, bistErr, desErr, countWrap
  );
endinterface : rsml_port_if

// File: logic/rsml_port_state.sv
// State of one serial port: address map, error counter and sticky flags.
// Assumes events arrive as one-cycle pulses on the block clock.
`include "rsml_cfg.svh"
module rsml_port_state (
  input wire logic sys_clk,
  input wire logic rst,
  rsml_port_if.st port
);
  import rsml_pkg::*;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port.target <= `RSML_RESET_ADDR;
      port.aliasAddr <= `RSML_RESET_ADDR;
    end else begin
      if (port.wrTarget) begin
        port.target <= port.wrData[7:1];
      end
      if (port.wrAlias) begin
        port.aliasAddr <= port.wrData[7:1];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port.count <= `RSML_RESET_COUNT;
      port.countWrap <= 1'b0;
    end else begin
      port.countWrap <= 1'b0;
      if (port.crcClear) begin
        port.count <= `RSML_RESET_COUNT;
      end else if (port.crcErr) begin
        port.count <= port.count + 16'h0001;
        port.countWrap <= (port.count == 16'hffff);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port.linkLost <= 1'b0;
    end else if (port.linkDownEvt) begin
      port.linkLost <= 1'b1;
    end else if (port.crcClear) begin
      port.linkLost <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port.bistErr <= 1'b0;
    end else if (port.crcErr && port.bistActive) begin
      port.bistErr <= 1'b1;
    end else if (port.linkDownEvt || port.bistRestart || port.crcClear) begin
      port.bistErr <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port.desErr <= 1'b0;
    end else if (port.crcErr && !port.bistActive) begin
      port.desErr <= 1'b1;
    end else if (port.linkDownEvt || port.crcClear) begin
      port.desErr <= 1'b0;
    end
  end
endmodule : rsml_port_state

// File: logic/rsml_top.sv
// Register group for remote slave address mapping and back-channel health.
// Assumes link detect and clock detect arrive asynchronously from the link
// front end; CRC error pulses, self-test activity and I2C requests come from
// logic on sys_clk.
`include "rsml_cfg.svh"

module rsml_top #(
  parameter int NUM_PORTS = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire rsml_pkg::rsml_byte_t regAddr,
  input wire rsml_pkg::rsml_byte_t regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output rsml_pkg::rsml_byte_t regRdData,
  output logic irq,
  input wire logic [1:0] linkDetectPin,
  input wire logic clockDetectPin,
  input wire logic [1:0] backCrcErr,
  input wire logic [1:0] selfTestActive,
  input wire logic reqValid,
  input wire rsml_pkg::rsml_i2c_addr_t reqAddr,
  output logic fwdValid,
  output rsml_pkg::rsml_i2c_addr_t fwdAddr,
  output rsml_pkg::rsml_port_t fwdPort,
  output logic fwdBlocked,
  output logic fwdLocal
);
  import rsml_pkg::*;

  // Decodes whether an address hits a given register offset.
  function automatic logic hits(input rsml_byte_t addr, input rsml_byte_t ofs);
    hits = (addr == ofs);
  endfunction : hits

  // Decodes whether a mapping entry is enabled and matches an address.
  function automatic logic mapHit(input rsml_i2c_addr_t tgt, input rsml_i2c_addr_t als,
                                  input rsml_i2c_addr_t addr);
    mapHit = (als != `RSML_RESET_ADDR) && (tgt != `RSML_RESET_ADDR) && (als == addr);
  endfunction : mapHit

  rsml_port_if ports [NUM_PORTS] ();

  logic portSel_reg;
  rsml_byte_t irqStatus_reg;
  rsml_byte_t irqStatus_next;
  rsml_byte_t irqMask_reg;
  logic crcClear_reg;
  logic crcClearPort_reg;
  logic [1:0] linkMeta_reg;
  logic [1:0] linkSync_reg;
  logic [1:0] linkPrev_reg;
  logic clockMeta_reg;
  logic clockSync_reg;
  logic clockPrev_reg;
  logic [1:0] bistPrev_reg;
  rsml_byte_t statusSel;
  rsml_i2c_addr_t selTarget;
  rsml_i2c_addr_t selAlias;
  rsml_count_t selCount;
  logic selLinkLost;
  logic selBistErr;
  logic selDesErr;
  logic selLinkUp;
  logic [NUM_PORTS-1:0] evtLost;
  logic [NUM_PORTS-1:0] evtDes;
  logic [NUM_PORTS-1:0] evtBist;
  logic [NUM_PORTS-1:0] evtWrap;
  logic [NUM_PORTS-1:0] mapMatch;
  logic [NUM_PORTS-1:0] aliasMatch;
  rsml_i2c_addr_t [NUM_PORTS-1:0] targets;
  rsml_i2c_addr_t [NUM_PORTS-1:0] aliases;
  rsml_count_t [NUM_PORTS-1:0] counts;
  logic [NUM_PORTS-1:0] lostFlags;
  logic [NUM_PORTS-1:0] bistFlags;
  logic [NUM_PORTS-1:0] desFlags;
  logic wrCtrl;
  logic rdIrqStatus;
  logic wrPortSel;
  logic wrMask;
  logic wrTargetAny;
  logic wrAliasAny;

  assign wrCtrl = regWr && hits(regAddr, `RSML_OFS_CONTROL);
  assign rdIrqStatus = regRd && hits(regAddr, `RSML_OFS_IRQ_STATUS);
  assign wrPortSel = regWr && hits(regAddr, `RSML_OFS_PORT_SELECT);
  assign wrMask = regWr && hits(regAddr, `RSML_OFS_IRQ_MASK);
  assign wrTargetAny = regWr && hits(regAddr, `RSML_OFS_TARGET);
  assign wrAliasAny = regWr && hits(regAddr, `RSML_OFS_ALIAS);

  // Link detect comes from outside the clock domain.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      linkMeta_reg <= 2'h0;
      linkSync_reg <= 2'h0;
    end else begin
      linkMeta_reg <= linkDetectPin;
      linkSync_reg <= linkMeta_reg;
    end
  end

  // Previous synchronised link state, used to find a loss of link.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      linkPrev_reg <= 2'h0;
    end else begin
      linkPrev_reg <= linkSync_reg;
    end
  end

  // Clock detect comes from outside the clock domain as well.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clockMeta_reg <= 1'b0;
      clockSync_reg <= 1'b0;
    end else begin
      clockMeta_reg <= clockDetectPin;
      clockSync_reg <= clockMeta_reg;
    end
  end

  // Previous synchronised clock state, used to flag a change of clock.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clockPrev_reg <= 1'b0;
    end else begin
      clockPrev_reg <= clockSync_reg;
    end
  end

  // A rising edge of self-test activity marks a restart.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bistPrev_reg <= 2'h0;
    end else begin
      bistPrev_reg <= selfTestActive;
    end
  end

  // The reset bit acts as a one-cycle pulse and reads back as zero.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      crcClear_reg <= 1'b0;
    end else begin
      crcClear_reg <= wrCtrl && regWrData[`RSML_BIT_CRC_RESET];
    end
  end

  // The clear goes to the port selected at the write edge, not at the pulse.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      crcClearPort_reg <= 1'b0;
    end else if (wrCtrl) begin
      crcClearPort_reg <= portSel_reg;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      portSel_reg <= 1'b0;
    end else if (wrPortSel) begin
      portSel_reg <= regWrData[`RSML_BIT_PORT_SELECT];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irqMask_reg <= `RSML_RESET_BYTE;
    end else if (wrMask) begin
      irqMask_reg <= regWrData;
    end
  end

  // Each port gets its own state block; writes reach only the selected one.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi = gi + 1) begin : g_port
      logic isSel;
      assign isSel = (portSel_reg == 1'(gi));
      assign ports[gi].wrTarget = wrTargetAny && isSel;
      assign ports[gi].wrAlias = wrAliasAny && isSel;
      assign ports[gi].wrData = regWrData;
      assign ports[gi].crcClear = crcClear_reg && (crcClearPort_reg == 1'(gi));
      assign ports[gi].crcErr = backCrcErr[gi];
      assign ports[gi].bistActive = selfTestActive[gi];
      assign ports[gi].bistRestart = selfTestActive[gi] && !bistPrev_reg[gi];
      assign ports[gi].linkUp = linkSync_reg[gi];
      assign ports[gi].linkDownEvt = linkPrev_reg[gi] && !linkSync_reg[gi];
      assign targets[gi] = ports[gi].target;
      assign aliases[gi] = ports[gi].aliasAddr;
      assign counts[gi] = ports[gi].count;
      assign lostFlags[gi] = ports[gi].linkLost;
      assign bistFlags[gi] = ports[gi].bistErr;
      assign desFlags[gi] = ports[gi].desErr;
      assign evtLost[gi] = ports[gi].linkDownEvt;
      assign evtDes[gi] = backCrcErr[gi] && !selfTestActive[gi];
      assign evtBist[gi] = backCrcErr[gi] && selfTestActive[gi];
      assign evtWrap[gi] = ports[gi].countWrap;
      assign aliasMatch[gi] = (ports[gi].aliasAddr == reqAddr) &&
                              (ports[gi].aliasAddr != `RSML_RESET_ADDR);
      assign mapMatch[gi] = mapHit(ports[gi].target, ports[gi].aliasAddr, reqAddr);
      rsml_port_state u_state (
        .sys_clk(sys_clk),
        .rst(rst),
        .port(ports[gi])
      );
    end
  endgenerate

  // Per-port view steered by the port-select bit.
  always_comb begin
    selTarget = targets[portSel_reg];
    selAlias = aliases[portSel_reg];
    selCount = counts[portSel_reg];
    selLinkLost = lostFlags[portSel_reg];
    selBistErr = bistFlags[portSel_reg];
    selDesErr = desFlags[portSel_reg];
    selLinkUp = linkSync_reg[portSel_reg];
  end

  always_comb begin
    statusSel = `RSML_RESET_BYTE;
    statusSel[`RSML_BIT_LINK_LOST] = selLinkLost;
    statusSel[`RSML_BIT_SELF_TEST_ERR] = selBistErr;
    statusSel[`RSML_BIT_CLOCK_PRESENT] = clockSync_reg;
    statusSel[`RSML_BIT_REMOTE_ERR] = selDesErr;
    statusSel[`RSML_BIT_LINK_DETECT] = selLinkUp;
  end

  // Sticky event bits; a new event in the read cycle survives the clear.
  always_comb begin
    irqStatus_next = irqStatus_reg;
    if (rdIrqStatus) begin
      irqStatus_next = `RSML_RESET_BYTE;
    end
    if (|evtLost) begin
      irqStatus_next[`RSML_IRQ_LINK_LOST] = 1'b1;
    end
    if (|evtDes) begin
      irqStatus_next[`RSML_IRQ_REMOTE_ERR] = 1'b1;
    end
    if (|evtBist) begin
      irqStatus_next[`RSML_IRQ_SELF_TEST_ERR] = 1'b1;
    end
    if (clockSync_reg != clockPrev_reg) begin
      irqStatus_next[`RSML_IRQ_CLOCK_CHANGE] = 1'b1;
    end
    if (|evtWrap) begin
      irqStatus_next[`RSML_IRQ_COUNT_WRAP] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irqStatus_reg <= `RSML_RESET_BYTE;
    end else begin
      irqStatus_reg <= irqStatus_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus_next & irqMask_reg);
    end
  end

  // Read data stand in the cycle after the read strobe only.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regRdData <= `RSML_RESET_BYTE;
    end else if (!regRd) begin
      regRdData <= `RSML_RESET_BYTE;
    end else begin
      unique case (regAddr)
        `RSML_OFS_TARGET: begin
          regRdData <= {selTarget, 1'b0};
        end
        `RSML_OFS_ALIAS: begin
          regRdData <= {selAlias, 1'b0};
        end
        `RSML_OFS_COUNT_LOW: begin
          regRdData <= selCount[7:0];
        end
        `RSML_OFS_COUNT_HIGH: begin
          regRdData <= selCount[15:8];
        end
        `RSML_OFS_STATUS: begin
          regRdData <= statusSel;
        end
        `RSML_OFS_PORT_SELECT: begin
          regRdData <= {7'h00, portSel_reg};
        end
        `RSML_OFS_IRQ_STATUS: begin
          regRdData <= irqStatus_reg;
        end
        `RSML_OFS_IRQ_MASK: begin
          regRdData <= irqMask_reg;
        end
        default: begin
          regRdData <= `RSML_RESET_BYTE;
        end
      endcase
    end
  end

  // Address translation: port 0 wins if both ports hold enabled entries for the same alias.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fwdValid <= 1'b0;
      fwdAddr <= `RSML_RESET_ADDR;
      fwdPort <= 1'b0;
      fwdBlocked <= 1'b0;
      fwdLocal <= 1'b0;
    end else begin
      fwdValid <= 1'b0;
      fwdBlocked <= 1'b0;
      fwdLocal <= 1'b0;
      if (reqValid) begin
        if (mapMatch[0]) begin
          fwdValid <= 1'b1;
          fwdAddr <= targets[0];
          fwdPort <= 1'b0;
        end else if (mapMatch[NUM_PORTS-1]) begin
          fwdValid <= 1'b1;
          fwdAddr <= targets[NUM_PORTS-1];
          fwdPort <= 1'b1;
        end else if (|aliasMatch) begin
          fwdBlocked <= 1'b1;
        end else begin
          fwdLocal <= 1'b1;
        end
      end
    end
  end
endmodule : rsml_top

// File: testbench/rsml_top_asserts.sv
// Checker for the remote slave map register group, bound to its top module.
// Assumes one clock domain with an asynchronous active-high reset.
module rsml_top_asserts #(
  parameter int NUM_PORTS = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire rsml_pkg::rsml_byte_t regAddr,
  input wire rsml_pkg::rsml_byte_t regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire rsml_pkg::rsml_byte_t regRdData,
  input wire logic irq,
  input wire logic [1:0] linkDetectPin,
  input wire logic clockDetectPin,
  input wire logic [1:0] backCrcErr,
  input wire logic [1:0] selfTestActive,
  input wire logic reqValid,
  input wire rsml_pkg::rsml_i2c_addr_t reqAddr,
  input wire logic fwdValid,
  input wire rsml_pkg::rsml_i2c_addr_t fwdAddr,
  input wire rsml_pkg::rsml_port_t fwdPort,
  input wire logic fwdBlocked,
  input wire logic fwdLocal
);
  timeunit 1ns;
  timeprecision 1ps;
  import rsml_pkg::*;
  logic selShadow;
  logic [2:0] pinsQ, stableCnt;
  // Shadow of the port-select bit.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) selShadow <= 1'b0;
    else if (regWr && regAddr == 8'h10) selShadow <= regWrData[0];
  end
  // Counts cycles since the detect pins last changed.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinsQ <= 3'h0;
      stableCnt <= 3'h0;
    end else begin
      pinsQ <= {linkDetectPin, clockDetectPin};
      if ({linkDetectPin, clockDetectPin} != pinsQ) stableCnt <= 3'h0;
      else if (stableCnt != 3'h7) stableCnt <= stableCnt + 3'h1;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  a_fwd_one_result: assert property ($past(reqValid) |->
    $onehot({fwdValid, fwdBlocked, fwdLocal})) else $error("not one request outcome");
  a_fwd_has_cause: assert property ((fwdValid || fwdBlocked || fwdLocal) |->
    $past(reqValid)) else $error("request outcome without request");
  a_fwd_nonzero_addr: assert property (fwdValid |->
    fwdAddr != 7'h00 && $past(reqAddr) != 7'h00) else $error("forward with zero address");
  a_blocked_alias: assert property (fwdBlocked |-> $past(reqAddr) != 7'h00)
    else $error("block on zero alias");
  a_fwd_hold: assert property (!fwdValid |-> $stable(fwdAddr) && $stable(fwdPort))
    else $error("forward address moved without forward");
  a_status_link: assert property ($past(regRd) && $past(regAddr) == 8'h0c &&
    $past(stableCnt) >= 3'h4 |-> regRdData[0] == linkDetectPin[$past(selShadow)])
    else $error("link detect bit wrong");
  a_status_clock: assert property ($past(regRd) && $past(regAddr) == 8'h0c &&
    $past(stableCnt) >= 3'h4 |-> regRdData[2] == clockDetectPin && regRdData[7:5] == 3'h0)
    else $error("clock detect bit wrong");
  a_addr_bit_zero: assert property ($past(regRd) &&
    ($past(regAddr) == 8'h07 || $past(regAddr) == 8'h08) |-> regRdData[0] == 1'b0)
    else $error("reserved address bit set");
endmodule : rsml_top_asserts

bind rsml_top rsml_top_asserts #(.NUM_PORTS(NUM_PORTS)) u_asserts (.sys_clk(sys_clk),
  .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .irq(irq), .linkDetectPin(linkDetectPin),
  .clockDetectPin(clockDetectPin), .backCrcErr(backCrcErr), .selfTestActive(selfTestActive),
  .reqValid(reqValid), .reqAddr(reqAddr), .fwdValid(fwdValid), .fwdAddr(fwdAddr),
  .fwdPort(fwdPort), .fwdBlocked(fwdBlocked), .fwdLocal(fwdLocal));

// File: testbench/rsml_link_model.sv
// Model of the link front end: detect pins, CRC error pulses, self-test.
// Assumes its tasks are entered just after a rising edge of sys_clk.
module rsml_link_model (
  input wire logic sys_clk,
  output logic [1:0] linkDetectPin,
  output logic clockDetectPin,
  output logic [1:0] backCrcErr,
  output logic [1:0] selfTestActive
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    linkDetectPin = 2'b00;
    clockDetectPin = 1'b0;
    backCrcErr = 2'b00;
    selfTestActive = 2'b00;
  end
  task automatic set_pins(input logic [1:0] link, input logic clk);
    linkDetectPin <= link;
    clockDetectPin <= clk;
    repeat (6) @(posedge sys_clk);
  endtask : set_pins
  // Sends n bad frames, back to back or with a gap between them.
  task automatic crc_burst(input int p, input int n, input int gap);
    repeat (n) begin
      backCrcErr[p] <= 1'b1;
      @(posedge sys_clk);
      if (gap > 0) begin
        backCrcErr[p] <= 1'b0;
        repeat (gap) @(posedge sys_clk);
      end
    end
    backCrcErr[p] <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : crc_burst
  task automatic self_test(input int p, input logic v);
    selfTestActive[p] <= v;
    repeat (2) @(posedge sys_clk);
  endtask : self_test
endmodule : rsml_link_model

// File: testbench/testbench.sv
// Self-checking bench for the remote slave map register group.
// Assumes the link model drives the front-end pins.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rsml_pkg::*;
  logic sys_clk, rst, regWr, regRd, reqValid, irq, fwdValid, fwdBlocked, fwdLocal;
  rsml_byte_t regAddr, regWrData, regRdData, d;
  rsml_i2c_addr_t reqAddr, fwdAddr, lastAddr;
  rsml_port_t fwdPort, lastPort;
  logic [1:0] linkDetectPin, backCrcErr, selfTestActive;
  logic clockDetectPin;
  rsml_i2c_addr_t tgt [2];
  rsml_i2c_addr_t als [2];
  rsml_byte_t offs [6] = '{8'h07, 8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h20};
  int miscompares, nTests, n;
  rsml_top #(.NUM_PORTS(2)) DUT (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq),
    .linkDetectPin(linkDetectPin), .clockDetectPin(clockDetectPin), .backCrcErr(backCrcErr),
    .selfTestActive(selfTestActive), .reqValid(reqValid), .reqAddr(reqAddr),
    .fwdValid(fwdValid), .fwdAddr(fwdAddr), .fwdPort(fwdPort), .fwdBlocked(fwdBlocked),
    .fwdLocal(fwdLocal));
  rsml_link_model link (.sys_clk(sys_clk), .linkDetectPin(linkDetectPin),
    .clockDetectPin(clockDetectPin), .backCrcErr(backCrcErr), .selfTestActive(selfTestActive));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic giveVerdict();
    if (miscompares == 0 && nTests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : giveVerdict
  task automatic wr(input rsml_byte_t a, input rsml_byte_t v);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input rsml_byte_t a, output rsml_byte_t v);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 v = regRdData;
    @(posedge sys_clk);
  endtask : rd
  task automatic rdc(input rsml_byte_t a, input rsml_byte_t exp);
    rsml_byte_t v;
    rd(a, v);
    check(v, exp);
  endtask : rdc
  task automatic chk_irq(input logic exp);
    @(posedge sys_clk);
    #1 check(irq, exp);
    @(posedge sys_clk);
  endtask : chk_irq
  // Outcome bits valid, blocked, local, then port and address.
  function automatic logic [10:0] fwd_exp(input rsml_i2c_addr_t a);
    for (int p = 0; p < 2; p++) begin
      if (a == als[p] && a != 7'h00) return {(tgt[p] == 7'h00) ? 3'b010 : 3'b100, p[0], tgt[p]};
    end
    return {3'b001, 1'b0, 7'h00};
  endfunction : fwd_exp
  task automatic req(input rsml_i2c_addr_t a);
    logic [10:0] e;
    logic [15:0] s;
    e = fwd_exp(a);
    if (e[10]) {lastPort, lastAddr} = e[7:0];
    reqAddr <= a;
    reqValid <= 1'b1;
    @(posedge sys_clk);
    reqValid <= 1'b0;
    #1 s = {5'h0, fwdValid, fwdBlocked, fwdLocal, fwdPort, fwdAddr};
    check(s, {5'h0, e[10:8], lastPort, lastAddr});
    @(posedge sys_clk);
  endtask : req
  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    giveVerdict();
  end
  initial begin
    {rst, regWr, regRd, reqValid, regAddr, regWrData, reqAddr} = {4'h8, 23'h0};
    {lastAddr, lastPort, miscompares, nTests} = '0;
    void'($urandom(32'h9e55));
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    foreach (offs[i]) rdc(offs[i], 8'h00);
    link.set_pins(2'b11, 1'b1);
    for (int p = 0; p < 2; p++) begin
      wr(8'h10, {7'h00, p[0]});
      rdc(8'h0c, 8'h05);
    end
    for (int k = 0; k < 12; k++) begin
      tgt[0] = (k == 0) ? 7'h00 : 7'($urandom);
      tgt[1] = 7'($urandom);
      als[0] = 7'($urandom);
      als[1] = (k == 1) ? 7'h00 : 7'($urandom);
      if (als[1] == als[0]) als[1] = als[0] ^ 7'h01;
      for (int p = 0; p < 2; p++) begin
        wr(8'h10, {7'h00, p[0]});
        wr(8'h07, {tgt[p], 1'b1});
        wr(8'h08, {als[p], 1'b1});
      end
      for (int p = 0; p < 2; p++) begin
        wr(8'h10, {7'h00, p[0]});
        rdc(8'h07, {tgt[p], 1'b0});
        rdc(8'h08, {als[p], 1'b0});
      end
      req(als[0]);
      req(als[1]);
      req(7'($urandom));
    end
    wr(8'h0a, 8'hff);
    rdc(8'h0a, 8'h00);
    for (int p = 0; p < 2; p++) begin
      n = 1 + $urandom % 6;
      wr(8'h10, {7'h00, p[0]});
      link.crc_burst(p, n, $urandom % 3);
      rdc(8'h0a, 8'(n));
      rdc(8'h0a, 8'(n));
      rdc(8'h0c, 8'h07);
      wr(8'h10, {7'h00, ~p[0]});
      rdc(8'h0a, 8'h00);
      wr(8'h10, {7'h00, p[0]});
      link.self_test(p, 1'b1);
      link.crc_burst(p, 1, 0);
      rdc(8'h0c, 8'h0f);
      link.self_test(p, 1'b0);
      link.self_test(p, 1'b1);
      rdc(8'h0c, 8'h07);
      link.self_test(p, 1'b0);
      wr(8'h04, 8'h20);
      rdc(8'h0a, 8'h00);
      rdc(8'h0c, 8'h05);
    end
    wr(8'h10, 8'h00);
    link.crc_burst(0, 300, 0);
    rdc(8'h0a, 8'h2c);
    rdc(8'h0b, 8'h01);
    link.set_pins(2'b10, 1'b1);
    rdc(8'h0c, 8'h14);
    link.set_pins(2'b11, 1'b1);
    rdc(8'h0c, 8'h15);
    wr(8'h04, 8'h20);
    rdc(8'h0c, 8'h05);
    rdc(8'h0b, 8'h00);
    wr(8'h12, 8'h02);
    rd(8'h11, d);
    link.crc_burst(0, 1, 0);
    chk_irq(1'b1);
    rdc(8'h11, 8'h02);
    chk_irq(1'b0);
    wr(8'h12, 8'h00);
    link.crc_burst(0, 1, 1);
    chk_irq(1'b0);
    wr(8'h12, 8'h02);
    chk_irq(1'b1);
    rd(8'h11, d);
    chk_irq(1'b0);
    giveVerdict();
  end
endmodule : testbench
